/* vmem_pkg.sv */
// constants, types and register map of the voltage angle memory
package vmem_pkg;
   localparam int NV = 6;
   localparam int NI = 3;
   localparam int NCOND = 6;
   localparam int NEV = 12;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_VTHR   = 8'h04;
   localparam logic [7:0] ADDR_IPICK  = 8'h08;
   localparam logic [7:0] ADDR_HOLD   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_EVENT  = 8'h14;
   localparam logic [7:0] ADDR_MASK   = 8'h18;

   localparam int CTRL_EN     = 0;
   localparam int CTRL_GATE   = 1;
   localparam int CTRL_FORCED = 2;
   localparam int CTRL_F60    = 3;

   localparam logic [3:0]  CTRL_RST  = 4'h0;
   localparam logic [15:0] VTHR_RST  = 16'h000A;
   localparam logic [15:0] IPICK_RST = 16'h01F4;
   localparam logic [15:0] HOLD_RST  = 16'h0032;

   localparam logic [15:0] VTHR_MIN  = 16'h0002;
   localparam logic [15:0] VTHR_MAX  = 16'h0032;
   localparam logic [15:0] HOLD_MIN  = 16'h0002;
   localparam logic [15:0] HOLD_MAX  = 16'h1388;
   localparam logic [15:0] VOLT_SCALE = 16'h0064;

   localparam int CLK_NS = 50;
   localparam int HOLD_STEP_NS = 10_000_000;
   localparam int HOLD_STEP_CYCLES = HOLD_STEP_NS / CLK_NS;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACTIVE,
      ST_EXPIRED
   } vmem_state_e;

   typedef struct packed {
      logic [NV-1:0]        v_used;
      logic [NV-1:0][15:0]  v_mag;
      logic [NV-1:0][15:0]  v_ang;
      logic [NI-1:0][15:0]  i_mag;
   } meas_s;

   typedef struct packed {
      logic [NV-1:0][15:0]  amp;
      logic [NV-1:0][15:0]  ang;
   } vref_s;
endpackage

/* voltage_angle_memory.sv */
// voltage angle memory with avalon register slave and event interrupt
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module voltage_angle_memory #(
   parameter int STEP_CYCLES = vmem_pkg::HOLD_STEP_CYCLES
) (
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   input  wire logic [7:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   output logic [31:0]                readdata,
   output logic                       waitrequest,
   input  wire logic                  cycle_start,
   input  wire logic                  block_in,
   input  wire vmem_pkg::meas_s       meas,
   output vmem_pkg::vref_s            vref,
   output logic                       mem_in_use,
   output logic                       non_directed,
   output logic                       freq_from_phase_three,
   output logic                       nominal_60hz,
   output logic                       irq
);
   import vmem_pkg::*;

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic                   rst_meta_n;
   logic                   rst_n;
   logic                   ack;
   logic [3:0]             ctrl;
   logic [15:0]            vthr;
   logic [15:0]            ipick;
   logic [15:0]            hold;
   logic [NEV-1:0]         ev;
   logic [NEV-1:0]         mask;
   vmem_state_e            st;
   vmem_state_e            next_st;
   logic [17:0]            presc;
   logic [15:0]            hold_cnt;
   logic                   lv_det;
   logic                   ih_det;
   logic                   blocked;
   logic                   ff_det;
   logic [NV-1:0][15:0]    ang_store;
   logic [NCOND-1:0]       cond_prev;

   // reset release through two flops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // settings decode
   wire         en        = ctrl[CTRL_EN];
   wire         gate      = ctrl[CTRL_GATE];
   wire [15:0]  vthr_eff  = clamp(vthr, VTHR_MIN, VTHR_MAX);
   wire [15:0]  hold_eff  = clamp(hold, HOLD_MIN, HOLD_MAX);
   wire [15:0]  thr_cent  = 16'(vthr_eff * VOLT_SCALE);

   // measurement conditions
   logic [NV-1:0] v_low;
   logic [NI-1:0] i_high;
   genvar gi;
   generate
      for (gi = 0; gi < NV; gi++) begin : g_v
         assign v_low[gi] = !meas.v_used[gi] || (meas.v_mag[gi] < thr_cent);
      end
      for (gi = 0; gi < NI; gi++) begin : g_i
         assign i_high[gi] = meas.i_mag[gi] > ipick;
      end
   endgenerate

   wire lv_now   = (&v_low) && (|meas.v_used);
   wire ih_now   = |i_high;
   wire act_ok   = en && !block_in && lv_now && (!gate || ih_now);
   wire drop     = !en || block_in || !lv_now;
   wire hold_hit = hold_cnt >= hold_eff;

   // program-cycle state
   always_comb begin
      next_st = st;
      case (st)
         ST_IDLE:    if (act_ok) next_st = ST_ACTIVE;
         ST_ACTIVE:  if (drop) next_st = ST_IDLE;
                     else if (hold_hit) next_st = ST_EXPIRED;
         ST_EXPIRED: if (drop) next_st = ST_IDLE;
         default:    next_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st      <= ST_IDLE;
         lv_det  <= 1'b0;
         ih_det  <= 1'b0;
         blocked <= 1'b0;
         ff_det  <= 1'b0;
      end else if (cycle_start) begin
         st      <= next_st;
         lv_det  <= lv_now;
         ih_det  <= ih_now;
         blocked <= block_in;
         ff_det  <= en && ctrl[CTRL_FORCED] && lv_now;
      end
   end

   // hold timer in 10 ms steps from activation
   wire step_end = presc == 18'(STEP_CYCLES - 1);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         presc    <= 18'h00000;
         hold_cnt <= 16'h0000;
      end else if (st != ST_ACTIVE) begin
         presc    <= 18'h00000;
         hold_cnt <= 16'h0000;
      end else begin
         presc    <= step_end ? 18'h00000 : presc + 18'h00001;
         if (step_end && !hold_hit) hold_cnt <= hold_cnt + 16'h0001;
      end
   end

   // angles follow while idle, frozen from activation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) ang_store <= '0;
      else if (cycle_start && st == ST_IDLE && !act_ok) ang_store <= meas.v_ang;
   end

   // reference outputs
   assign mem_in_use            = st == ST_ACTIVE;
   assign non_directed          = st == ST_EXPIRED;
   assign freq_from_phase_three = ff_det;
   assign nominal_60hz          = ctrl[CTRL_F60];
   generate
      for (gi = 0; gi < NV; gi++) begin : g_ref
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               vref.amp[gi] <= 16'h0000;
               vref.ang[gi] <= 16'h0000;
            end else begin
               vref.amp[gi] <= mem_in_use ? thr_cent : meas.v_mag[gi];
               vref.ang[gi] <= mem_in_use ? ang_store[gi] : meas.v_ang[gi];
            end
         end
      end
   endgenerate

   // paired on/off events
   wire [NCOND-1:0] cond = {blocked, mem_in_use, ff_det, ih_det, lv_det, en};
   logic [NEV-1:0] ev_set;
   generate
      for (gi = 0; gi < NCOND; gi++) begin : g_ev
         assign ev_set[2*gi]   = cond[gi] && !cond_prev[gi];
         assign ev_set[2*gi+1] = !cond[gi] && cond_prev[gi];
      end
   endgenerate

   // avalon slave, one wait state
   wire req     = read || write;
   wire wr_go   = write && ack;
   wire sel_ev  = address == ADDR_EVENT;
   wire [NEV-1:0] w1c = (wr_go && sel_ev) ? writedata[NEV-1:0] : '0;
   assign waitrequest = req && !ack;

   logic [31:0] rd_mux;
   always_comb begin
      case (address)
         ADDR_CTRL:   rd_mux = {28'h0000000, ctrl};
         ADDR_VTHR:   rd_mux = {16'h0000, vthr};
         ADDR_IPICK:  rd_mux = {16'h0000, ipick};
         ADDR_HOLD:   rd_mux = {16'h0000, hold};
         ADDR_STATUS: rd_mux = {26'h0000000, ff_det, blocked, non_directed, mem_in_use, ih_det, lv_det};
         ADDR_EVENT:  rd_mux = {20'h00000, ev};
         ADDR_MASK:   rd_mux = {20'h00000, mask};
         default:     rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack      <= 1'b0;
         readdata <= 32'h00000000;
      end else begin
         ack <= req && !ack;
         if (read && !ack) readdata <= rd_mux;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl  <= CTRL_RST;
         vthr  <= VTHR_RST;
         ipick <= IPICK_RST;
         hold  <= HOLD_RST;
         mask  <= '0;
      end else if (wr_go) begin
         if (address == ADDR_CTRL)  ctrl  <= writedata[3:0];
         if (address == ADDR_VTHR)  vthr  <= clamp(writedata[15:0], VTHR_MIN, VTHR_MAX);
         if (address == ADDR_IPICK) ipick <= writedata[15:0];
         if (address == ADDR_HOLD)  hold  <= clamp(writedata[15:0], HOLD_MIN, HOLD_MAX);
         if (address == ADDR_MASK)  mask  <= writedata[NEV-1:0];
      end
   end

   // sticky events, a set beats a clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ev        <= '0;
         cond_prev <= '0;
         irq       <= 1'b0;
      end else begin
         ev        <= (ev & ~w1c) | ev_set;
         cond_prev <= cond;
         irq       <= |(((ev & ~w1c) | ev_set) & mask);
      end
   end

   // checks
   property p_lowv;
      @(posedge mclk) disable iff (!rst_n)
      cycle_start && st == ST_IDLE && en && !block_in && lv_now && !gate |=> mem_in_use;
   endproperty
   a_lowv: assert property (p_lowv) else $error("memory did not engage on low voltage");

   property p_gate;
      @(posedge mclk) disable iff (!rst_n)
      cycle_start && st == ST_IDLE && gate && !ih_now |=> !mem_in_use;
   endproperty
   a_gate: assert property (p_gate) else $error("engaged without overcurrent");

   property p_thr;
      @(posedge mclk) disable iff (!rst_n)
      vthr_eff >= 16'h0002 && vthr_eff <= 16'h0032;
   endproperty
   a_thr: assert property (p_thr) else $error("threshold outside range");

   property p_amp;
      @(posedge mclk) disable iff (!rst_n)
      mem_in_use |=> vref.amp[0] == $past(thr_cent);
   endproperty
   a_amp: assert property (p_amp) else $error("amplitude not threshold");

   property p_ang;
      @(posedge mclk) disable iff (!rst_n)
      mem_in_use ##1 mem_in_use |-> $stable(ang_store) && vref.ang[1] == $past(ang_store[1]);
   endproperty
   a_ang: assert property (p_ang) else $error("angle moved while active");

   property p_use;
      @(posedge mclk) disable iff (!rst_n)
      $rose(mem_in_use) |-> $past(cycle_start) && $past(lv_now);
   endproperty
   a_use: assert property (p_use) else $error("use began without cause");

   property p_exp;
      @(posedge mclk) disable iff (!rst_n)
      cycle_start && mem_in_use && hold_hit && !drop |=> non_directed && !mem_in_use;
   endproperty
   a_exp: assert property (p_exp) else $error("no non-directed mode after expiry");

   property p_blk;
      @(posedge mclk) disable iff (!rst_n)
      cycle_start |=> blocked == $past(block_in) && (!blocked || !mem_in_use);
   endproperty
   a_blk: assert property (p_blk) else $error("blocking not taken");

   property p_dis;
      @(posedge mclk) disable iff (!rst_n)
      !en && !mem_in_use |=> !mem_in_use;
   endproperty
   a_dis: assert property (p_dis) else $error("engaged while disabled");

   property p_ev;
      @(posedge mclk) disable iff (!rst_n)
      $rose(lv_det) |=> ev[2];
   endproperty
   a_ev: assert property (p_ev) else $error("low voltage event lost");

   c_active: cover property (@(posedge mclk) disable iff (!rst_n) $rose(mem_in_use));
   c_expire: cover property (@(posedge mclk) disable iff (!rst_n) $rose(non_directed));
   c_irq:    cover property (@(posedge mclk) disable iff (!rst_n) $rose(irq));
endmodule

/* vmem_stage_model.sv */
// partner model: program cycle source and direction consumer of the stages
`timescale 1ns/100ps
module vmem_stage_model #(
   parameter int PERIOD = 8
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        mem_in_use,
   input  wire logic        non_directed,
   output logic             cycle_start,
   output logic [1:0]       dir_mode
);
   int cnt;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
         cycle_start <= 1'b0;
         dir_mode <= 2'h0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         cycle_start <= (cnt == PERIOD - 1);
         // 0 live angle, 1 memory angle, 2 non-directed
         if (cycle_start) begin
            dir_mode <= non_directed ? 2'h2 : {1'b0, mem_in_use};
         end
      end
   end
endmodule

/* tb_top.sv */
// self-checking testbench of the voltage angle memory
`timescale 1ns/100ps
module tb_top;
   import vmem_pkg::*;
   logic           mclk;
   logic           resetn;
   logic [7:0]     address;
   logic           read;
   logic           write;
   logic [31:0]    writedata;
   logic [31:0]    readdata;
   logic           waitrequest;
   logic           cycle_start;
   logic           block_in;
   meas_s          meas;
   vref_s          vref;
   logic           mem_in_use;
   logic           non_directed;
   logic           freq_from_phase_three;
   logic           nominal_60hz;
   logic           irq;
   logic [1:0]     dir_mode;
   int             n_errors;
   int             checked;
   int             ticks = 0;
   logic [31:0]    q;

   voltage_angle_memory #(.STEP_CYCLES(4)) dut (.mclk(mclk), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .cycle_start(cycle_start), .block_in(block_in), .meas(meas), .vref(vref), .mem_in_use(mem_in_use),
      .non_directed(non_directed), .freq_from_phase_three(freq_from_phase_three),
      .nominal_60hz(nominal_60hz), .irq(irq));
   vmem_stage_model #(.PERIOD(8)) stages (.mclk(mclk), .resetn(resetn), .mem_in_use(mem_in_use),
      .non_directed(non_directed), .cycle_start(cycle_start), .dir_mode(dir_mode));

   always #25 mclk = ~mclk;

   task automatic close_out;
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge mclk) begin
      ticks <= ticks + 1;
      if (ticks == 20000) begin
         n_errors++;
         close_out;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      @(posedge mclk);
      // hold the request until waitrequest is seen low at a rising edge
      while (waitrequest !== 1'b0) @(posedge mclk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // one program cycle evaluated, events and irq settled
   task automatic ev;
      @(posedge mclk iff cycle_start === 1'b1);
      repeat (4) @(posedge mclk);
   endtask

   task automatic setv(input logic [15:0] mag, input logic [15:0] ang);
      for (int i = 0; i < NV; i++) begin
         meas.v_mag[i] <= mag;
         meas.v_ang[i] <= ang + 16'(i);
      end
      meas.v_used <= 6'h3F;
   endtask

   // the given event bits must be set; all are then cleared
   task automatic evchk(input logic [31:0] m);
      xfer(1'b0, ADDR_EVENT, 32'h0);
      chk(q & m, m);
      xfer(1'b1, ADDR_EVENT, 32'h0000_0FFF);
   endtask

   task automatic t_regs;
      logic [7:0]  a [5] = '{ADDR_CTRL, ADDR_VTHR, ADDR_IPICK, ADDR_HOLD, 8'h1C};
      logic [31:0] e [5] = '{32'h0, 32'h0A, 32'h1F4, 32'h32, 32'h0};
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, a[i], 32'h0);
         chk(q, e[i]);
      end
      xfer(1'b1, ADDR_VTHR, 32'h1);
      xfer(1'b0, ADDR_VTHR, 32'h0);
      chk(q, 32'h2);
      xfer(1'b1, ADDR_VTHR, 32'h63);
      xfer(1'b0, ADDR_VTHR, 32'h0);
      chk(q, 32'h32);
      xfer(1'b1, ADDR_HOLD, 32'h270F);
      xfer(1'b0, ADDR_HOLD, 32'h0);
      chk(q, 32'h1388);
      xfer(1'b1, ADDR_VTHR, 32'h14);
      xfer(1'b1, ADDR_HOLD, 32'h20);
      xfer(1'b1, ADDR_MASK, 32'h0000_0FFF);
   endtask

   task automatic t_disabled;
      setv(16'h0064, 16'h0);
      ev;
      chk(32'(mem_in_use), 32'h0);
      setv(16'h59D8, 16'h0);
      xfer(1'b1, ADDR_CTRL, 32'h1);
      ev;
      evchk(32'h1);
   endtask

   task automatic t_partial;
      // voltage 5 stays high
      for (int i = 0; i < NV - 1; i++) meas.v_mag[i] <= 16'h0064;
      ev;
      chk(32'(mem_in_use), 32'h0);
      meas.v_used[5] <= 1'b0;
      ev;
      chk(32'(mem_in_use), 32'h1);
      setv(16'h59D8, 16'h0);
      ev;
      chk(32'(mem_in_use), 32'h0);
      xfer(1'b1, ADDR_EVENT, 32'h0000_0FFF);
   endtask

   task automatic t_activate;
      setv(16'h59D8, 16'h0BB8);
      ev;
      chk(32'(vref.ang[3]), 32'h0BBB);
      setv(16'h0064, 16'h1B58);
      ev;
      chk({31'h0, mem_in_use}, 32'h1);
      chk(32'(vref.amp[3]), 32'h07D0);
      chk(32'(vref.ang[3]), 32'h0BBB);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h5);
      xfer(1'b1, ADDR_MASK, 32'h0);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, ADDR_MASK, 32'h0000_0FFF);
      evchk(32'h104);
      setv(16'h59D8, 16'h0);
      ev;
      chk({31'h0, mem_in_use}, 32'h0);
      evchk(32'h208);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic t_gate;
      xfer(1'b1, ADDR_CTRL, 32'h3);
      meas.i_mag <= {16'h0064, 16'h0064, 16'h0064};
      setv(16'h0064, 16'h0);
      ev;
      chk({31'h0, mem_in_use}, 32'h0);
      meas.i_mag[2] <= 16'h0258;
      ev;
      chk({31'h0, mem_in_use}, 32'h1);
      evchk(32'h10);
      meas.i_mag <= '0;
      setv(16'h59D8, 16'h0);
      ev;
      evchk(32'h20);
   endtask

   task automatic t_block;
      xfer(1'b1, ADDR_CTRL, 32'h1);
      block_in <= 1'b1;
      setv(16'h0064, 16'h0);
      ev;
      chk({31'h0, mem_in_use}, 32'h0);
      evchk(32'h400);
      block_in <= 1'b0;
      setv(16'h59D8, 16'h0);
      ev;
      evchk(32'h800);
   endtask

   task automatic t_expire;
      xfer(1'b1, ADDR_HOLD, 32'h2);
      setv(16'h0064, 16'h0);
      ev;
      chk({31'h0, mem_in_use}, 32'h1);
      for (int i = 0; i < 4 && non_directed !== 1'b1; i++) ev;
      chk({31'h0, non_directed}, 32'h1);
      chk({31'h0, mem_in_use}, 32'h0);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h9);
      ev;
      chk(32'(dir_mode), 32'h2);
      setv(16'h59D8, 16'h0);
      ev;
      chk({31'h0, non_directed}, 32'h0);
      xfer(1'b1, ADDR_EVENT, 32'h0000_0FFF);
   endtask

   task automatic t_forced;
      xfer(1'b1, ADDR_CTRL, 32'hD);
      ev;
      chk({31'h0, nominal_60hz}, 32'h1);
      setv(16'h0064, 16'h0);
      ev;
      chk({31'h0, freq_from_phase_three}, 32'h1);
      evchk(32'h40);
      setv(16'h59D8, 16'h0);
      ev;
      chk({31'h0, freq_from_phase_three}, 32'h0);
      evchk(32'h80);
      xfer(1'b1, ADDR_CTRL, 32'h0);
      ev;
      chk({31'h0, nominal_60hz}, 32'h0);
      evchk(32'h2);
   endtask

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      address = 8'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      block_in = 1'b0;
      meas = '0;
      n_errors = 0;
      checked = 0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      t_regs;
      t_disabled;
      t_partial;
      t_activate;
      t_gate;
      t_block;
      t_expire;
      t_forced;
      close_out;
   end
endmodule
